//--- rtl/sptl_driver.sv
// Logic core of the 16-channel serial-to-parallel latch driver.
// Assumes serial pins are asynchronous to ref_clk and sampled here.
`timescale 1ns/1ps
`include "sptl_map.svh"
module sptl_driver (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic data_in,
  input wire logic latch_load_n,
  input wire logic polarity_n,
  output logic data_out,
  output sptl_pkg::sptl_word_type drive_out,
  output logic backplane_out,
  output sptl_pkg::sptl_word_type latch_word,
  output logic word_valid,
  input wire logic word_ready,
  output logic shift_stall
);
  import sptl_pkg::*;

  // ---------------------------------------------
  // Input synchronisers
  // ---------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic sclk_q;
  logic din_s;
  logic le_n_s;
  logic pol_s;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      sclk_q <= 1'b0;
    end else begin
      sync_a <= {serial_clk, data_in, latch_load_n, polarity_n};
      sync_b <= sync_a;
      sclk_q <= sync_b[3];
    end
  end

  // Data delayed one stage so it matches the clock edge it was set up for
  logic din_d;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      din_d <= 1'b0;
    end else begin
      din_d <= sync_b[2];
    end
  end
  assign din_s = din_d;
  assign le_n_s = sync_b[1];
  assign pol_s = sync_b[0];

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sync_b[3] && !sclk_q;
  assign sclk_fall = !sync_b[3] && sclk_q;

  // ---------------------------------------------
  // Shift register
  // ---------------------------------------------
  sptl_word_type sreg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sreg <= `SPTL_SREG_RESET;
    end else if (sclk_rise) begin
      // Bit 0 is stage one, bit 15 stage sixteen
      sreg <= {sreg[`SPTL_WIDTH-2:0], din_s};
    end
  end

  // Serial output follows stage sixteen on the falling edge only,
  // so the next device sees it stable at its rising edge.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_out <= 1'b0;
    end else if (sclk_fall) begin
      data_out <= sreg[`SPTL_WIDTH-1];
    end
  end

  // ---------------------------------------------
  // Latch
  // ---------------------------------------------
  sptl_word_type latch;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latch <= `SPTL_LATCH_RESET;
    end else if (!le_n_s) begin
      latch <= sreg;
    end
    // Held while latch_load_n is high
  end

  // ---------------------------------------------
  // Output drivers
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      drive_out <= ~`SPTL_LATCH_RESET;
      backplane_out <= 1'b1;
    end else begin
      // Only latch and polarity reach the outputs
      drive_out <= pol_s ? latch : ~latch;
      backplane_out <= !pol_s;
    end
  end

  // ---------------------------------------------
  // Latched-word stream
  // ---------------------------------------------
  // Each change of the latch is queued; a stalled consumer raises
  // shift_stall, which the host must honour since pins cannot pause.
  sptl_word_type latch_prev;
  logic push;
  logic fifo_ready;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latch_prev <= `SPTL_LATCH_RESET;
    end else if (fifo_ready) begin
      latch_prev <= latch;
    end
  end
  assign push = (latch != latch_prev);
  assign shift_stall = !fifo_ready;

  sptl_fifo #(
    .WIDTH(`SPTL_WIDTH),
    .DEPTH(`SPTL_FIFO_DEPTH),
    .AW(`SPTL_FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(latch),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(latch_word)
  );
endmodule

//--- rtl/sptl_map.svh
// Constants for the 16-channel serial-to-parallel latch driver.
// Assumes a 200 MHz ref_clk; serial pins arrive asynchronously.
`ifndef SPTL_MAP_SVH
`define SPTL_MAP_SVH

`define SPTL_WIDTH 16
`define SPTL_SREG_RESET 16'h0000
`define SPTL_LATCH_RESET 16'h0000
`define SPTL_FIFO_DEPTH 8
`define SPTL_FIFO_AW 3
`define SPTL_CLK_MHZ 200
`define SPTL_SCLK_MAX_KHZ 500
// Least serial clock period in ref_clk cycles
`define SPTL_SCLK_MIN_CYC ((`SPTL_CLK_MHZ * 1000 + `SPTL_SCLK_MAX_KHZ - 1) / `SPTL_SCLK_MAX_KHZ)

`endif

//--- rtl/sptl_pkg.sv
// Types for the serial-to-parallel latch driver.
// Assumes sptl_map.svh is on the include path.
`include "sptl_map.svh"
package sptl_pkg;
  typedef logic [`SPTL_WIDTH-1:0] sptl_word_type;
  typedef enum logic [1:0] {
    SPTL_IDLE = 2'b00,
    SPTL_HIGH = 2'b01
  } sptl_sclk_state_type;
endpackage

//--- rtl/sptl_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data come from a register.
`timescale 1ns/1ps
module sptl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ---------------------------------------------
  // Storage
  // ---------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Registered head; refilled after each pop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (!out_valid || out_ready) begin
      out_valid <= (count != '0) && !(out_valid && count == (AW+1)'(1));
      out_data <= out_valid ? mem[rptr + 1'b1] : mem[rptr];
    end
  end
endmodule

//--- testbench/sptl_driver_properties.sv
// Port assertions for the latch driver.
// Assumes bind to sptl_driver; serial half period far above 8 cycles.
`timescale 1ns/1ps
module sptl_driver_properties (
  input logic ref_clk,
  input logic rstn,
  input logic serial_clk,
  input logic data_in,
  input logic latch_load_n,
  input logic polarity_n,
  input logic data_out,
  input sptl_pkg::sptl_word_type drive_out,
  input logic backplane_out,
  input sptl_pkg::sptl_word_type latch_word,
  input logic word_valid,
  input logic word_ready,
  input logic shift_stall
);
  import sptl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_RESET_VAL: assert property ($rose(rstn) |-> drive_out == 16'hFFFF && backplane_out)
    else $error("bad reset outputs");
  AST_POL_TRUE: assert property (polarity_n [*8] |-> !backplane_out)
    else $error("backplane not low");
  AST_POL_INV: assert property (!polarity_n [*8] |-> backplane_out)
    else $error("backplane not high");
  AST_HOLD: assert property ((latch_load_n && $stable(polarity_n)) [*8] |-> $stable(drive_out))
    else $error("held outputs moved");
  AST_INVERT: assert property ($changed(backplane_out) && $past(latch_load_n, 6) && latch_load_n
    |-> drive_out == ~$past(drive_out))
    else $error("polarity did not invert");
  AST_DOUT_FALL: assert property ($changed(data_out) |-> !serial_clk && !$past(serial_clk, 2))
    else $error("serial out moved off fall");
  AST_STALL_FULL: assert property (shift_stall |-> word_valid)
    else $error("stall with empty queue");
  AST_HEAD_HOLD: assert property (word_valid && !word_ready |=> word_valid && $stable(latch_word))
    else $error("queue head dropped");
endmodule

bind sptl_driver sptl_driver_properties u_props (.*);

//--- testbench/sptl_host_model.sv
// Host model: shifts serial data into the driver.
// Assumes ref_clk at 200 MHz; clock stands low between bits.
`timescale 1ns/1ps
module sptl_host_model (
  input logic ref_clk,
  input logic data_out,
  output logic serial_clk = 1'b0,
  output logic data_in = 1'b0
);
  import sptl_pkg::*;
  sptl_word_type chain = 16'h0000;
  // 200 cycles each half keeps 500 kHz
  task automatic shift_bit(input logic b);
    repeat (100) @(posedge ref_clk);
    #1 data_in = b;
    repeat (100) @(posedge ref_clk);
    #1 serial_clk = 1'b1;
    chain = {chain[14:0], data_out};
    repeat (200) @(posedge ref_clk);
    #1 serial_clk = 1'b0;
    data_in = ~b;
  endtask
  task automatic shift_word(input sptl_word_type w);
    for (int i = 15; i >= 0; i--) shift_bit(w[i]);
  endtask
endmodule

//--- testbench/sptl_driver_tb.sv
// Self-checking bench for the latch driver.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/1ps
module sptl_driver_tb;
  import sptl_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, latch_load_n = 1'b1, polarity_n = 1'b1, word_ready = 1'b1;
  logic serial_clk, data_in, data_out, backplane_out, word_valid, shift_stall;
  sptl_word_type drive_out, latch_word, q[$];
  int fail_count = 0, num_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  sptl_driver dut (.*);
  sptl_host_model host (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [16:0] g, e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Latch pulse well above the sync delay
  task automatic load;
    latch_load_n = 1'b0;
    tick(10);
    latch_load_n = 1'b1;
    tick(10);
  endtask
  task automatic t_latch;
    chk({backplane_out, drive_out}, 17'h1FFFF);
    rstn = 1'b1;
    tick(8);
    host.shift_word(16'hA5C3);
    chk({backplane_out, drive_out}, 17'h00000);
    load;
    chk({backplane_out, drive_out}, 17'h0A5C3);
    polarity_n = 1'b0;
    tick(8);
    chk({backplane_out, drive_out}, 17'h15A3C);
    host.shift_word(16'h3C96);
    chk(17'(host.chain), 17'h0A5C3);
    chk(17'(drive_out), 17'h05A3C);
  endtask
  task automatic t_fifo;
    sptl_word_type s = 16'h3C96;
    word_ready = 1'b0;
    for (int i = 0; i < 8; i++) begin
      host.shift_bit(i[0]);
      s = {s[14:0], i[0]};
      q.push_back(s);
      load;
    end
    chk(17'(shift_stall), 17'h00001);
    word_ready = 1'b1;
    foreach (q[j]) begin
      while (word_valid !== 1'b1) tick(1);
      chk(17'(latch_word), 17'(q[j]));
      tick(1);
    end
    tick(4);
    chk(17'(word_valid), 17'h00000);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(16);
    t_latch;
    t_fifo;
    end_of_test;
  end
  // Run needs about 16200 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    end_of_test;
  end
endmodule
